// >>> src/acc_pkg.sv
// Package with register map, field positions, reset values and timing for the converter control block.
package acc_pkg;
    // Register offsets on the plain register port.
    localparam logic [3:0] OFF_STATUS_FIRST = 4'h0;
    localparam logic [3:0] OFF_STATUS_SECOND = 4'h1;
    localparam logic [3:0] OFF_RESULT_UPPER = 4'h2;
    localparam logic [3:0] OFF_RESULT_LOWER = 4'h3;
    localparam logic [3:0] OFF_COMPARE_HIGH = 4'h4;
    localparam logic [3:0] OFF_COMPARE_LOW = 4'h5;
    localparam logic [3:0] OFF_CONFIG = 4'h6;
    localparam logic [3:0] OFF_PIN_FIRST = 4'h7;
    localparam logic [3:0] OFF_PIN_SECOND = 4'h8;
    localparam logic [3:0] OFF_POWER_STATE = 4'h9;
    // Field positions in the first status/control register.
    localparam int SC1_COMPLETE = 7;
    localparam int SC1_IRQ_EN = 6;
    localparam int SC1_CONTINUOUS = 5;
    // Field positions in the second status/control register.
    localparam int SC2_ACTIVE = 7;
    localparam int SC2_TRIGGER = 6;
    localparam int SC2_CMP_EN = 5;
    localparam int SC2_CMP_GT = 4;
    // Field positions in the configuration register.
    localparam int CFG_LOW_POWER = 7;
    localparam int CFG_DIV_LSB = 5;
    localparam int CFG_LONG_SAMPLE = 4;
    localparam int CFG_MODE_LSB = 2;
    localparam int CFG_CLK_LSB = 0;
    // Encodings.
    localparam logic [1:0] MODE_8BIT = 2'h0;
    localparam logic [1:0] MODE_10BIT = 2'h2;
    localparam logic [1:0] CLK_BUS = 2'h0;
    localparam logic [1:0] CLK_ASYNC = 2'h3;
    localparam logic [4:0] CHANNEL_OFF = 5'h1f;
    // Reset values.
    localparam logic [7:0] RST_STATUS_FIRST = 8'h1f;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // Cycle counts of a conversion in converter-clock periods.
    localparam logic [5:0] CYC_SHORT_8 = 6'h11;
    localparam logic [5:0] CYC_SHORT_10 = 6'h14;
    localparam logic [5:0] CYC_LONG_8 = 6'h25;
    localparam logic [5:0] CYC_LONG_10 = 6'h28;
    localparam logic [1:0] PWR_RUN = 2'h0;
    localparam logic [1:0] PWR_STOP3 = 2'h1;
    localparam logic [1:0] PWR_DEEP = 2'h2;
endpackage : acc_pkg

// >>> src/acc_converter_control.sv
// Converter control: register file, conversion sequencing, compare and low-power handling.
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/100ps
module acc_converter_control
    import acc_pkg::*;
(
    input wire logic clk_sys, // System clock, 200 MHz.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic asyncClk, // Asynchronous converter clock, sampled as a level.
    input wire logic hwTrigger, // Hardware trigger pulse.
    input wire logic [1:0] powerMode, // Low-power mode from the system.
    input wire logic [3:0] regAddr, // Register address.
    input wire logic [7:0] regWdata, // Register write data.
    input wire logic regWrite, // Write strobe.
    input wire logic regRead, // Read strobe.
    input wire logic [9:0] sampleData, // Digitised value from the analog core.
    output logic [7:0] regRdata, // Read data, valid the cycle after a read.
    output logic convIrq, // Conversion-complete interrupt request.
    output logic [4:0] channelSel, // Channel routed to the analog core.
    output logic convBusy, // Analog core active.
    output logic lowPowerSel, // Low-power bias to analog core.
    output logic [15:0] pinIoDisable // Per-pin general-purpose I/O disable.
);
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_RUN = 2'b01,
        ACC_DONE = 2'b10
    } acc_state_t;

    // Reset synchroniser stages.
    logic rstMeta;
    logic rstSync;
    // Software-visible registers.
    logic [7:0] statusFirst;
    logic [7:0] statusSecond;
    logic [7:0] convConfig;
    logic [7:0] cmpHigh;
    logic [7:0] cmpLow;
    logic [7:0] pinFirst;
    logic [7:0] pinSecond;
    // Held result and the copy kept for the low-byte read.
    logic [9:0] result;
    logic [9:0] latchedLow;
    logic readLock; // High between the upper and the lower result read.
    // Converter clock generation.
    logic [2:0] divCount;
    logic asyncMeta;
    logic asyncSync;
    logic asyncPrev;
    // Sequencer.
    logic [5:0] cycCount;
    acc_state_t state;
    acc_state_t next_state;

    // Reset release through two flip-flops.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // Power-mode decode; stop3 aborts only when the async clock is not selected.
    wire deepStop = (powerMode == PWR_DEEP);
    wire inStop3 = (powerMode == PWR_STOP3);
    wire asyncSelected = (convConfig[CFG_CLK_LSB +: 2] == CLK_ASYNC);
    wire stopAbort = inStop3 && !asyncSelected;

    // Register write and read strobes per address.
    wire wrFirst = regWrite && (regAddr == OFF_STATUS_FIRST);
    wire wrSecond = regWrite && (regAddr == OFF_STATUS_SECOND);
    wire wrConfig = regWrite && (regAddr == OFF_CONFIG);
    wire wrCmpHigh = regWrite && (regAddr == OFF_COMPARE_HIGH);
    wire wrCmpLow = regWrite && (regAddr == OFF_COMPARE_LOW);
    wire wrPinFirst = regWrite && (regAddr == OFF_PIN_FIRST);
    wire wrPinSecond = regWrite && (regAddr == OFF_PIN_SECOND);
    wire wrOther = wrSecond || wrConfig || wrCmpHigh || wrCmpLow; // A mode change invalidates a conversion.
    wire rdUpper = regRead && (regAddr == OFF_RESULT_UPPER);
    wire rdLower = regRead && (regAddr == OFF_RESULT_LOWER);

    // Conversion start and abort requests.
    wire channelOn = (statusFirst[4:0] != CHANNEL_OFF);
    wire swStart = wrFirst && (regWdata[4:0] != CHANNEL_OFF) && !statusSecond[SC2_TRIGGER];
    wire hwStart = statusSecond[SC2_TRIGGER] && hwTrigger && channelOn;
    wire contStart = statusFirst[SC1_CONTINUOUS] && channelOn;
    wire abortNow = wrOther || stopAbort || (wrFirst && !swStart);
    // A write to a status, configuration or compare register in the same cycle wins over a hardware or continuous start.
    wire idleStart = swStart || (!stopAbort && !wrFirst && !wrOther && (hwStart || contStart));

    // Resolution, sample time and conversion length.
    wire is10 = (convConfig[CFG_MODE_LSB +: 2] == MODE_10BIT);
    wire longSample = convConfig[CFG_LONG_SAMPLE];
    wire [5:0] convLength = longSample ? (is10 ? CYC_LONG_10 : CYC_LONG_8)
        : (is10 ? CYC_SHORT_10 : CYC_SHORT_8);
    wire [9:0] sampleMasked = is10 ? sampleData : {2'b00, sampleData[9:2]};

    // Compare: the result plus the two's complement of the compare value.
    wire [9:0] cmpValue = {cmpHigh[1:0], cmpLow};
    wire [10:0] cmpDiff = {1'b0, sampleMasked} + {1'b0, ~cmpValue} + 11'h001;
    wire cmpGe = cmpDiff[10];
    wire cmpPass = !statusSecond[SC2_CMP_EN] || (statusSecond[SC2_CMP_GT] ? cmpGe : !cmpGe);
    wire [9:0] transferValue = statusSecond[SC2_CMP_EN] ? cmpDiff[9:0] : sampleMasked;
    // A transfer is held off while the result is locked between the two reads.
    wire transferNow = (state == ACC_DONE) && cmpPass && !readLock;

    // Converter clock: the divided bus clock or rising edges of the synchronised async clock.
    wire [3:0] divLimit = 4'(1) << convConfig[CFG_DIV_LSB +: 2];
    wire busTick = ({1'b0, divCount} == divLimit - 4'h1);
    wire asyncTick = asyncSync && !asyncPrev;
    wire convTick = asyncSelected ? asyncTick : busTick;

    // Sequencer state change.
    always_comb begin
        next_state = state;
        unique case (state)
            ACC_IDLE: begin
                if (idleStart) begin
                    next_state = ACC_RUN;
                end
            end
            ACC_RUN: begin
                if (abortNow) begin
                    next_state = swStart ? ACC_RUN : ACC_IDLE;
                end else if (convTick && (cycCount == convLength)) begin
                    next_state = ACC_DONE;
                end
            end
            ACC_DONE: begin
                next_state = ACC_IDLE;
            end
            default: begin
                next_state = ACC_IDLE;
            end
        endcase
    end

    // Synchronise the asynchronous converter clock; only the second stage feeds the edge detector.
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            asyncMeta <= 1'b0;
            asyncSync <= 1'b0;
            asyncPrev <= 1'b0;
        end else begin
            asyncMeta <= asyncClk;
            asyncSync <= asyncMeta;
            asyncPrev <= asyncSync;
        end
    end

    // Bus clock divider, one tick every 1, 2, 4 or 8 cycles.
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            divCount <= 3'h0;
        end else begin
            divCount <= busTick ? 3'h0 : divCount + 3'h1;
        end
    end

    // Sequencer state and conversion cycle counter; deep stop forces idle.
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            state <= ACC_IDLE;
            cycCount <= 6'h00;
        end else if (deepStop) begin
            state <= ACC_IDLE;
            cycCount <= 6'h00;
        end else begin
            state <= next_state;
            if (next_state != ACC_RUN || (abortNow && swStart)) begin
                cycCount <= 6'h00;
            end else if (convTick) begin
                cycCount <= cycCount + 6'h01;
            end
        end
    end

    // First status/control register; completion sets the flag and the set wins over a clearing access.
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            statusFirst <= RST_STATUS_FIRST;
        end else if (deepStop) begin
            statusFirst <= RST_STATUS_FIRST;
        end else begin
            if (transferNow) begin
                statusFirst[SC1_COMPLETE] <= 1'b1;
            end else if (wrFirst || rdLower) begin
                statusFirst[SC1_COMPLETE] <= 1'b0;
            end
            if (wrFirst) begin
                statusFirst[6:0] <= regWdata[6:0];
            end
        end
    end

    // Second status/control register; bit 7 is shown live and bits 3:2 are never stored.
    acc_byte_reg #(
        .RESET_VALUE(RST_ZERO),
        .WRITE_MASK(8'h73)
    ) i_status_second (
        .clk_sys(clk_sys),
        .resetn(rstSync),
        .clear(deepStop),
        .load(wrSecond),
        .wdata(regWdata),
        .value(statusSecond)
    );

    // Configuration register.
    acc_byte_reg #(
        .RESET_VALUE(RST_ZERO),
        .WRITE_MASK(8'hff)
    ) i_config (
        .clk_sys(clk_sys),
        .resetn(rstSync),
        .clear(deepStop),
        .load(wrConfig),
        .wdata(regWdata),
        .value(convConfig)
    );

    // Compare value, upper two bits.
    acc_byte_reg #(
        .RESET_VALUE(RST_ZERO),
        .WRITE_MASK(8'h03)
    ) i_cmp_high (
        .clk_sys(clk_sys),
        .resetn(rstSync),
        .clear(deepStop),
        .load(wrCmpHigh),
        .wdata(regWdata),
        .value(cmpHigh)
    );

    // Compare value, lower eight bits.
    acc_byte_reg #(
        .RESET_VALUE(RST_ZERO),
        .WRITE_MASK(8'hff)
    ) i_cmp_low (
        .clk_sys(clk_sys),
        .resetn(rstSync),
        .clear(deepStop),
        .load(wrCmpLow),
        .wdata(regWdata),
        .value(cmpLow)
    );

    // Pin control for inputs 0 to 7.
    acc_byte_reg #(
        .RESET_VALUE(RST_ZERO),
        .WRITE_MASK(8'hff)
    ) i_pin_first (
        .clk_sys(clk_sys),
        .resetn(rstSync),
        .clear(deepStop),
        .load(wrPinFirst),
        .wdata(regWdata),
        .value(pinFirst)
    );

    // Pin control for inputs 8 to 15.
    acc_byte_reg #(
        .RESET_VALUE(RST_ZERO),
        .WRITE_MASK(8'hff)
    ) i_pin_second (
        .clk_sys(clk_sys),
        .resetn(rstSync),
        .clear(deepStop),
        .load(wrPinSecond),
        .wdata(regWdata),
        .value(pinSecond)
    );

    // Result transfer and high-then-low read interlock; a deep stop clears the result and the lock.
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            result <= 10'h000;
            latchedLow <= 10'h000;
            readLock <= 1'b0;
        end else if (deepStop) begin
            result <= 10'h000;
            latchedLow <= 10'h000;
            readLock <= 1'b0;
        end else begin
            if (transferNow) begin
                result <= transferValue;
            end
            if (rdUpper) begin
                readLock <= 1'b1;
                latchedLow <= result;
            end else if (rdLower || wrFirst) begin
                readLock <= 1'b0;
            end
        end
    end

    // Read data mux, registered for the next cycle.
    wire [7:0] statusSecondView = {convBusy, statusSecond[6:4], 2'b00, statusSecond[1:0]};
    wire [7:0] lowerView = readLock ? latchedLow[7:0] : result[7:0];
    logic [7:0] next_rdata;
    always_comb begin
        unique case (regAddr)
            OFF_STATUS_FIRST: next_rdata = statusFirst;
            OFF_STATUS_SECOND: next_rdata = statusSecondView;
            OFF_RESULT_UPPER: next_rdata = {6'h00, result[9:8]};
            OFF_RESULT_LOWER: next_rdata = lowerView;
            OFF_COMPARE_HIGH: next_rdata = cmpHigh;
            OFF_COMPARE_LOW: next_rdata = cmpLow;
            OFF_CONFIG: next_rdata = convConfig;
            OFF_PIN_FIRST: next_rdata = pinFirst;
            OFF_PIN_SECOND: next_rdata = pinSecond;
            OFF_POWER_STATE: next_rdata = {6'h00, powerMode};
            default: next_rdata = 8'h00;
        endcase
    end

    // Registered read data.
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            regRdata <= 8'h00;
        end else begin
            regRdata <= regRead ? next_rdata : 8'h00;
        end
    end

    // Outputs to the analog core, pins and interrupt controller.
    assign convBusy = (state != ACC_IDLE);
    assign convIrq = statusFirst[SC1_COMPLETE] && statusFirst[SC1_IRQ_EN];
    assign channelSel = statusFirst[4:0];
    assign lowPowerSel = convConfig[CFG_LOW_POWER];
    assign pinIoDisable = {pinSecond, pinFirst};
endmodule : acc_converter_control

// Byte register with a write mask; a deep stop returns it to its reset value.
module acc_byte_reg #(
    parameter logic [7:0] RESET_VALUE = 8'h00, // Value after reset and after a deep stop.
    parameter logic [7:0] WRITE_MASK = 8'hff // Bits that software can change.
) (
    input wire logic clk_sys, // System clock.
    input wire logic resetn, // Synchronised reset, active low.
    input wire logic clear, // Deep stop, returns the reset value.
    input wire logic load, // Write strobe for this register.
    input wire logic [7:0] wdata, // Write data.
    output logic [7:0] value // Register contents.
);
    // Bits outside the mask keep their reset value, so they always read back the same.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            value <= RESET_VALUE;
        end else if (clear) begin
            value <= RESET_VALUE;
        end else if (load) begin
            value <= (wdata & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
        end
    end
endmodule : acc_byte_reg

// >>> dv/acc_analog_model.sv
// Model of the analog core and the asynchronous converter clock beside the control block.
`timescale 1ns/100ps
module acc_analog_model (
    input wire logic [4:0] channelSel, // Channel picked by the block.
    input wire logic convBusy, // Core busy converting.
    output logic asyncClk, // Asynchronous converter clock.
    output logic [9:0] sampleData // Digitised value of the channel.
);
    // The asynchronous clock has its own period, unrelated in phase to the bus clock.
    initial begin
        asyncClk = 1'b0;
        forever #7.3 asyncClk = ~asyncClk;
    end
    // Each channel gives its own value; an idle core shows the inverse, so a stray capture shows up.
    assign sampleData = convBusy ? {channelSel, 5'h15} : ~{channelSel, 5'h15};
endmodule : acc_analog_model

// >>> dv/acc_converter_control_monitor.sv
// Port checker for the converter control block.
`timescale 1ns/100ps
module acc_converter_control_monitor
    import acc_pkg::*;
(
    input wire logic clk_sys, // System clock.
    input wire logic resetn, // Reset, active low.
    input wire logic asyncClk, // Asynchronous clock.
    input wire logic hwTrigger, // Hardware trigger.
    input wire logic [1:0] powerMode, // Power mode.
    input wire logic [3:0] regAddr, // Address.
    input wire logic [7:0] regWdata, // Write data.
    input wire logic regWrite, // Write strobe.
    input wire logic regRead, // Read strobe.
    input wire logic [9:0] sampleData, // Core value.
    input wire logic [7:0] regRdata, // Read data.
    input wire logic convIrq, // Interrupt request.
    input wire logic [4:0] channelSel, // Channel.
    input wire logic convBusy, // Core active.
    input wire logic lowPowerSel, // Low-power bias.
    input wire logic [15:0] pinIoDisable // Pin I/O disable.
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    // Decoded register writes that are not swallowed by a deep stop.
    wire logic wrFirst = regWrite && regAddr == OFF_STATUS_FIRST && powerMode != PWR_DEEP;
    wire logic wrConfig = regWrite && regAddr == OFF_CONFIG && powerMode != PWR_DEEP;
    wire logic wrPin = regWrite && regAddr == OFF_PIN_FIRST && powerMode != PWR_DEEP;
    // Register reads, writes and power-mode effects seen at the ports.
    property p_sc2_zero; regRead && regAddr == OFF_STATUS_SECOND |=> regRdata[3:2] == 2'b00; endproperty
    a_sc2_zero: assert property (p_sc2_zero) else $error("unimplemented bits read nonzero");
    property p_active; regRead && regAddr == OFF_STATUS_SECOND |=> regRdata[SC2_ACTIVE] == $past(convBusy); endproperty
    a_active: assert property (p_active) else $error("active flag differs from busy");
    property p_irq;
        regRead && regAddr == OFF_STATUS_FIRST |=> (regRdata[7] && regRdata[6]) == $past(convIrq);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt differs from flag and enable");
    property p_deep;
        powerMode == PWR_DEEP |=> !convBusy && !convIrq && channelSel == CHANNEL_OFF && pinIoDisable == 16'h0000;
    endproperty
    a_deep: assert property (p_deep) else $error("deep stop left state behind");
    property p_low_power; wrConfig |=> lowPowerSel == $past(regWdata[CFG_LOW_POWER]); endproperty
    a_low_power: assert property (p_low_power) else $error("low-power select not taken");
    property p_pin; wrPin |=> pinIoDisable[7:0] == $past(regWdata); endproperty
    a_pin: assert property (p_pin) else $error("pin control not taken");
    property p_channel; wrFirst |=> channelSel == $past(regWdata[4:0]); endproperty
    a_channel: assert property (p_channel) else $error("channel not taken");
    property p_ch_off; wrFirst && regWdata[4:0] == CHANNEL_OFF |=> !convBusy; endproperty
    a_ch_off: assert property (p_ch_off) else $error("disabled channel left core busy");
    // Main scenarios reached.
    c_done: cover property ($fell(convBusy));
    c_irq: cover property ($rose(convIrq));
    c_deep: cover property (powerMode == PWR_DEEP ##1 powerMode == PWR_RUN);
endmodule : acc_converter_control_monitor
bind acc_converter_control acc_converter_control_monitor i_monitor (.clk_sys(clk_sys), .resetn(resetn),
    .asyncClk(asyncClk), .hwTrigger(hwTrigger), .powerMode(powerMode), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .sampleData(sampleData), .regRdata(regRdata), .convIrq(convIrq),
    .channelSel(channelSel), .convBusy(convBusy), .lowPowerSel(lowPowerSel), .pinIoDisable(pinIoDisable));

// >>> dv/test_acc_converter_control.sv
// Self-checking testbench for the converter control block.
`timescale 1ns/100ps
module test_acc_converter_control;
    import acc_pkg::*;
    logic clk_sys, resetn, asyncClk, regWrite, regRead, convIrq, convBusy, lowPowerSel, hwTrigger;
    logic [1:0] powerMode;
    logic [3:0] regAddr;
    logic [7:0] regWdata, regRdata;
    logic [9:0] sampleData;
    logic [4:0] channelSel;
    logic [15:0] pinIoDisable;
    int failCount = 0;
    int comparisons = 0;
    acc_converter_control i_dut (.clk_sys(clk_sys), .resetn(resetn), .asyncClk(asyncClk), .hwTrigger(hwTrigger),
        .powerMode(powerMode), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .sampleData(sampleData), .regRdata(regRdata), .convIrq(convIrq), .channelSel(channelSel),
        .convBusy(convBusy), .lowPowerSel(lowPowerSel), .pinIoDisable(pinIoDisable));
    acc_analog_model i_analog (.channelSel(channelSel), .convBusy(convBusy), .asyncClk(asyncClk),
        .sampleData(sampleData));
    // Bus clock at 200 MHz.
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // Counts a comparison and reports a mismatch.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            failCount++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Prints the counts and the verdict, then ends the run.
    task automatic printVerdict();
        $display("comparisons %0d mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : printVerdict
    // One-cycle register write.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask : wr
    // One-cycle register read; the data stand in the following cycle only.
    task automatic rd8(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1 chk({8'h00, regRdata}, {8'h00, exp});
    endtask : rd8
    // Waits, bounded, until the core is idle, then two more edges for the flag to land.
    task automatic waitIdle(input int limit);
        int n = 0;
        #1;
        while (convBusy !== 1'b0) begin
            @(posedge clk_sys);
            n++;
            if (n > limit) begin
                failCount++;
                printVerdict();
            end
        end
        repeat (2) @(posedge clk_sys);
    endtask : waitIdle
    // Main sequence.
    initial begin
        resetn = 1'b0;
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 4'h0;
        regWdata = 8'h00;
        hwTrigger = 1'b0;
        powerMode = PWR_RUN;
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd8(OFF_STATUS_FIRST, RST_STATUS_FIRST);
        rd8(OFF_CONFIG, RST_ZERO);
        rd8(4'hf, RST_ZERO);
        $display("test reset values done");
        wr(OFF_CONFIG, 8'h98);
        wr(OFF_STATUS_SECOND, 8'h3c);
        rd8(OFF_STATUS_SECOND, 8'h30);
        wr(OFF_STATUS_SECOND, 8'h00);
        wr(OFF_PIN_FIRST, 8'h02);
        wr(OFF_STATUS_FIRST, 8'h59);
        #1 chk(16'(convBusy), 16'h0001);
        chk(pinIoDisable, 16'h0002);
        chk(16'({lowPowerSel, channelSel}), 16'h0039);
        rd8(OFF_STATUS_SECOND, 8'h80);
        rd8(OFF_CONFIG, 8'h98);
        waitIdle(500);
        #1 chk(16'(convIrq), 16'h0001);
        rd8(OFF_STATUS_FIRST, 8'hd9);
        rd8(OFF_RESULT_UPPER, 8'h03);
        rd8(OFF_RESULT_LOWER, 8'h35);
        chk(16'(convIrq), 16'h0000);
        $display("test single conversion done");
        wr(OFF_STATUS_FIRST, 8'h42);
        wr(OFF_STATUS_FIRST, 8'h1f);
        #1 chk(16'(convBusy), 16'h0000);
        wr(OFF_STATUS_FIRST, 8'h42);
        powerMode <= PWR_STOP3;
        repeat (2) @(posedge clk_sys);
        powerMode <= PWR_RUN;
        repeat (100) @(posedge clk_sys);
        #1 chk(16'(convBusy), 16'h0000);
        rd8(OFF_RESULT_UPPER, 8'h03);
        rd8(OFF_RESULT_LOWER, 8'h35);
        $display("test stop3 abort done");
        wr(OFF_CONFIG, {6'h00, CLK_ASYNC});
        wr(OFF_STATUS_FIRST, 8'h42);
        powerMode <= PWR_STOP3;
        waitIdle(2000);
        powerMode <= PWR_RUN;
        #1 chk(16'(convIrq), 16'h0001);
        rd8(OFF_RESULT_UPPER, 8'h00);
        rd8(OFF_RESULT_LOWER, 8'h15);
        wr(OFF_STATUS_SECOND, 8'h40);
        wr(OFF_STATUS_FIRST, 8'h42);
        powerMode <= PWR_STOP3;
        hwTrigger <= 1'b1;
        @(posedge clk_sys);
        hwTrigger <= 1'b0;
        waitIdle(2000);
        powerMode <= PWR_RUN;
        #1 chk(16'(convIrq), 16'h0001);
        rd8(OFF_RESULT_UPPER, 8'h00);
        rd8(OFF_RESULT_LOWER, 8'h15);
        $display("test stop3 with asynchronous clock done");
        @(posedge clk_sys);
        powerMode <= PWR_DEEP;
        repeat (2) @(posedge clk_sys);
        powerMode <= PWR_RUN;
        rd8(OFF_CONFIG, RST_ZERO);
        rd8(OFF_STATUS_FIRST, RST_STATUS_FIRST);
        rd8(OFF_RESULT_LOWER, RST_ZERO);
        chk(pinIoDisable, 16'h0000);
        $display("test deep stop done");
        printVerdict();
    end
endmodule : test_acc_converter_control
